// >>> logic/iod_decoder.sv
// Instruction opcode decoder with registered result
// Contract
// - Primary opcode is bits 31..26; 31..29 pick row, 28..26 column.
// - Opcode 000000 decodes bits 5..0; row 5..3, column 2..0.
// - Opcode 000001 decodes bits 20..16; row 20..19, column 18..16.
// - 64-bit level decodes dword add-immediates, dword loads and store.
// - Later level adds fp extended, prefetch and three conditional moves.
`timescale 1ns/100ps
module iod_decoder
  import iod_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Instruction from fetch
  input wire logic i_valid,
  input wire logic [IOD_INSTR_W-1:0] i_instr,
  input wire logic i_level_later,
  // Decode result to pipeline control
  output logic o_valid,
  output iod_group_t o_group,
  output iod_op_t o_op,
  output logic [IOD_FIELD_W-1:0] o_code,
  output logic o_reserved
);

  logic [IOD_FIELD_W-1:0] opc;
  logic [IOD_FIELD_W-1:0] fn;
  logic [IOD_ROW_W-1:0] opc_row;
  logic [IOD_ROW_W-1:0] opc_col;
  logic [IOD_RT_W-1:0] rt_field;
  logic [63:0] pri_map;
  logic [63:0] fn_map;
  iod_op_t ri_op;
  logic ri_reserved;

  logic valid_q, valid_d;
  iod_group_t group_q, group_d;
  iod_op_t op_q, op_d;
  logic [IOD_FIELD_W-1:0] code_q, code_d;
  logic reserved_q, reserved_d;

  assign opc = i_instr[IOD_OPC_MSB:IOD_OPC_LSB];
  assign opc_row = opc[IOD_FIELD_W-1:IOD_ROW_W];
  assign opc_col = opc[IOD_ROW_W-1:0];
  assign fn = i_instr[IOD_FN_MSB:IOD_FN_LSB];
  assign rt_field = i_instr[IOD_RT_MSB:IOD_RT_LSB];

  // Assigned code points depend on the level
  assign pri_map = i_level_later ? IOD_PRI_MAP_LATER : IOD_PRI_MAP_64;
  assign fn_map = i_level_later ? IOD_FN_MAP_LATER : IOD_FN_MAP_64;

  iod_reg_imm_dec u_reg_imm (
    .i_second_register_field(rt_field),
    .o_op(ri_op),
    .o_reserved(ri_reserved)
  );

  always_comb begin
    valid_d = i_valid;
    group_d = IOD_GRP_PRIMARY;
    op_d = IOD_OP_OTHER;
    code_d = opc;
    reserved_d = 1'b0;
    if (opc == IOD_OPC_FUNCTION_GROUP) begin
      group_d = IOD_GRP_FUNCTION;
      code_d = fn;
      reserved_d = ~fn_map[fn];
      if (reserved_d) begin
        op_d = IOD_OP_NONE;
      end else if (fn == IOD_FN_MOVE_ON_FP_FLAG) begin
        op_d = IOD_OP_MOVE_ON_FP_FLAG;
      end else if (fn == IOD_FN_MOVE_IF_ZERO) begin
        op_d = IOD_OP_MOVE_IF_ZERO;
      end else if (fn == IOD_FN_MOVE_IF_NONZERO) begin
        op_d = IOD_OP_MOVE_IF_NONZERO;
      end
    end else if (opc == IOD_OPC_REG_IMM_GROUP) begin
      group_d = IOD_GRP_REG_IMM;
      code_d = {1'b0, rt_field};
      op_d = ri_op;
      reserved_d = ri_reserved;
    end else begin
      reserved_d = ~pri_map[opc];
      if (reserved_d) begin
        op_d = IOD_OP_NONE;
      end else if (opc >= IOD_OPC_COP_FIRST && opc <= IOD_OPC_COP_LAST) begin
        op_d = IOD_OP_COPROC;
      end else if (opc == IOD_OPC_FP_EXTENDED) begin
        op_d = IOD_OP_FP_EXTENDED_GROUP;
      end else if (opc == IOD_OPC_PREFETCH) begin
        op_d = IOD_OP_PREFETCH;
      end else if (opc_row == IOD_ROW_DWORD) begin
        case (opc_col)
          IOD_COL_0: op_d = IOD_OP_DWORD_ADD_IMM_TRAPPING;
          IOD_COL_1: op_d = IOD_OP_DWORD_ADD_IMM;
          IOD_COL_2: op_d = IOD_OP_DWORD_LOAD_LEFT;
          IOD_COL_3: op_d = IOD_OP_DWORD_LOAD_RIGHT;
          default: op_d = IOD_OP_NONE;
        endcase
      end else if (opc_row == IOD_ROW_LOAD_HI && opc_col == IOD_COL_7) begin
        op_d = IOD_OP_DWORD_LOAD;
      end else if (opc_row == IOD_ROW_STORE_HI && opc_col == IOD_COL_7) begin
        op_d = IOD_OP_DWORD_STORE;
      end
    end
    // Flags only mean something alongside a valid word
    if (!i_valid) begin
      reserved_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      valid_q <= 1'b0;
      group_q <= IOD_GRP_PRIMARY;
      op_q <= IOD_OP_NONE;
      code_q <= '0;
      reserved_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
      group_q <= group_d;
      op_q <= op_d;
      code_q <= code_d;
      reserved_q <= reserved_d;
    end
  end

  assign o_valid = valid_q;
  assign o_group = group_q;
  assign o_op = op_q;
  assign o_code = code_q;
  assign o_reserved = reserved_q;

endmodule

// >>> logic/iod_pkg.sv
// Constants and types for the instruction opcode decoder
package iod_pkg;

  localparam int IOD_INSTR_W = 32;
  localparam int IOD_FIELD_W = 6;
  localparam int IOD_RT_W = 5;
  localparam int IOD_ROW_W = 3;
  localparam int IOD_RT_ROW_W = 2;

  // Field positions within the instruction word
  localparam int IOD_OPC_MSB = 31;
  localparam int IOD_OPC_LSB = 26;
  localparam int IOD_FN_MSB = 5;
  localparam int IOD_FN_LSB = 0;
  localparam int IOD_RT_MSB = 20;
  localparam int IOD_RT_LSB = 16;

  // Architecture level select
  localparam logic IOD_LEVEL_64 = 1'h0;
  localparam logic IOD_LEVEL_LATER = 1'h1;

  // Rows and columns of the primary table
  localparam logic [2:0] IOD_ROW_DWORD = 3'h3;
  localparam logic [2:0] IOD_ROW_LOAD_HI = 3'h6;
  localparam logic [2:0] IOD_ROW_STORE_HI = 3'h7;
  localparam logic [2:0] IOD_COL_0 = 3'h0;
  localparam logic [2:0] IOD_COL_1 = 3'h1;
  localparam logic [2:0] IOD_COL_2 = 3'h2;
  localparam logic [2:0] IOD_COL_3 = 3'h3;
  localparam logic [2:0] IOD_COL_4 = 3'h4;
  localparam logic [2:0] IOD_COL_6 = 3'h6;
  localparam logic [2:0] IOD_COL_7 = 3'h7;

  // Full opcode and function code points
  localparam logic [5:0] IOD_OPC_FUNCTION_GROUP = 6'h00;
  localparam logic [5:0] IOD_OPC_REG_IMM_GROUP = 6'h01;
  localparam logic [5:0] IOD_OPC_COP_FIRST = 6'h10;
  localparam logic [5:0] IOD_OPC_COP_LAST = 6'h12;
  localparam logic [5:0] IOD_OPC_FP_EXTENDED = 6'h13;
  localparam logic [5:0] IOD_OPC_PREFETCH = 6'h33;
  localparam logic [5:0] IOD_FN_MOVE_ON_FP_FLAG = 6'h01;
  localparam logic [5:0] IOD_FN_MOVE_IF_ZERO = 6'h0a;
  localparam logic [5:0] IOD_FN_MOVE_IF_NONZERO = 6'h0b;

  // Register-immediate trap row
  localparam logic [1:0] IOD_RT_ROW_TRAP = 2'h1;

  // Assigned code points, per level except the register-immediate map, bit index = row * 8 + column
  localparam logic [63:0] IOD_PRI_MAP_64 = 64'hf7f7_7fff_0ff7_ffff;
  localparam logic [63:0] IOD_PRI_MAP_LATER = 64'hf7ff_7fff_0fff_ffff;
  localparam logic [63:0] IOD_FN_MAP_64 = 64'hdd5f_fcff_ffdf_b3dd;
  localparam logic [63:0] IOD_FN_MAP_LATER = 64'hdd5f_fcff_ffdf_bfdf;
  localparam logic [31:0] IOD_RT_MAP = 32'h000f_5f0f;

  typedef enum logic [1:0] {
    IOD_GRP_PRIMARY,
    IOD_GRP_FUNCTION,
    IOD_GRP_REG_IMM
  } iod_group_t;

  typedef enum logic [4:0] {
    IOD_OP_NONE,
    IOD_OP_OTHER,
    IOD_OP_COPROC,
    IOD_OP_DWORD_ADD_IMM_TRAPPING,
    IOD_OP_DWORD_ADD_IMM,
    IOD_OP_DWORD_LOAD_LEFT,
    IOD_OP_DWORD_LOAD_RIGHT,
    IOD_OP_DWORD_LOAD,
    IOD_OP_DWORD_STORE,
    IOD_OP_FP_EXTENDED_GROUP,
    IOD_OP_PREFETCH,
    IOD_OP_MOVE_ON_FP_FLAG,
    IOD_OP_MOVE_IF_ZERO,
    IOD_OP_MOVE_IF_NONZERO,
    IOD_OP_TRAP_GE_IMM,
    IOD_OP_TRAP_GE_IMM_UNSIGNED,
    IOD_OP_TRAP_LT_IMM,
    IOD_OP_TRAP_LT_IMM_UNSIGNED,
    IOD_OP_TRAP_EQ_IMM,
    IOD_OP_TRAP_NE_IMM
  } iod_op_t;

endpackage

// >>> logic/iod_reg_imm_dec.sv
// Register-immediate group decoder, combinational
`timescale 1ns/100ps
module iod_reg_imm_dec
  import iod_pkg::*;
(
  // Second register field
  input wire logic [IOD_RT_W-1:0] i_second_register_field,
  // Decode result
  output iod_op_t o_op,
  output logic o_reserved
);

  logic [IOD_RT_ROW_W-1:0] row;
  logic [IOD_ROW_W-1:0] col;

  assign row = i_second_register_field[IOD_RT_W-1:IOD_ROW_W];
  assign col = i_second_register_field[IOD_ROW_W-1:0];
  assign o_reserved = ~IOD_RT_MAP[i_second_register_field];

  always_comb begin
    o_op = IOD_OP_OTHER;
    if (o_reserved) begin
      o_op = IOD_OP_NONE;
    end else if (row == IOD_RT_ROW_TRAP) begin
      case (col)
        IOD_COL_0: o_op = IOD_OP_TRAP_GE_IMM;
        IOD_COL_1: o_op = IOD_OP_TRAP_GE_IMM_UNSIGNED;
        IOD_COL_2: o_op = IOD_OP_TRAP_LT_IMM;
        IOD_COL_3: o_op = IOD_OP_TRAP_LT_IMM_UNSIGNED;
        IOD_COL_4: o_op = IOD_OP_TRAP_EQ_IMM;
        IOD_COL_6: o_op = IOD_OP_TRAP_NE_IMM;
        default: o_op = IOD_OP_NONE;
      endcase
    end
  end

endmodule

// >>> tb/iod_decoder_assertions.sv
// Port checks for the opcode decoder
`timescale 1ns/100ps
module iod_decoder_chk
  import iod_pkg::*;
(
  // Decoder inputs
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_valid,
  input wire logic [IOD_INSTR_W-1:0] i_instr,
  input wire logic i_level_later,
  // Decoder outputs
  input wire logic o_valid,
  input wire iod_group_t o_group,
  input wire iod_op_t o_op,
  input wire logic [IOD_FIELD_W-1:0] o_code,
  input wire logic o_reserved
);
  wire logic [5:0] opc = i_instr[31:26];
  wire logic [4:0] rt = i_instr[20:16];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  property p_pri;
    opc > 6'h01 |=> o_group == IOD_GRP_PRIMARY && o_code == $past(opc);
  endproperty
  a_pri: assert property (p_pri) else $error("primary code");
  property p_fn;
    opc == 6'h00 |=> o_group == IOD_GRP_FUNCTION &&
      o_code == $past(i_instr[5:0]);
  endproperty
  a_fn: assert property (p_fn) else $error("function code");
  property p_rt;
    opc == 6'h01 |=> o_group == IOD_GRP_REG_IMM &&
      o_code == {1'b0, $past(rt)};
  endproperty
  a_rt: assert property (p_rt) else $error("reg-imm code");
  property p_dw;
    opc == 6'h3f |=> o_op == IOD_OP_DWORD_STORE;
  endproperty
  a_dw: assert property (p_dw) else $error("dword store");
  property p_pf;
    opc == 6'h33 |=>
      o_op == ($past(i_level_later) ? IOD_OP_PREFETCH : IOD_OP_NONE);
  endproperty
  a_pf: assert property (p_pf) else $error("prefetch level");
  property p_trap;
    opc == 6'h01 && rt == 5'h0e |=> o_op == IOD_OP_TRAP_NE_IMM;
  endproperty
  a_trap: assert property (p_trap) else $error("trap not-equal");
  property p_res;
    i_valid && opc == 6'h1c |=> o_reserved && o_op == IOD_OP_NONE;
  endproperty
  a_res: assert property (p_res) else $error("reserved flag");
  property p_gate;
    !i_valid |=> !o_reserved;
  endproperty
  a_gate: assert property (p_gate) else $error("reserved gate");
  c_res: cover property (o_reserved);
  c_mz: cover property (o_op == IOD_OP_MOVE_IF_ZERO);
  c_tr: cover property (o_op == IOD_OP_TRAP_NE_IMM);
  c_pf: cover property (o_op == IOD_OP_PREFETCH);
endmodule
bind iod_decoder iod_decoder_chk u_chk (.i_clk, .i_resetn, .i_valid,
  .i_instr, .i_level_later, .o_valid, .o_group, .o_op, .o_code, .o_reserved);

// >>> tb/iod_fetch_model.sv
// Fetch stage model feeding instruction words to the decoder
`timescale 1ns/100ps
module iod_fetch_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Requests from the bench
  input wire logic i_valid,
  input wire logic [31:0] i_instr,
  input wire logic i_level_later,
  // Word to the decoder
  output logic o_valid,
  output logic [31:0] o_instr,
  output logic o_level_later
);
  // Idle word bus shows the inverse of its last value
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_valid <= 1'b0;
      o_instr <= 32'h0000_0000;
      o_level_later <= 1'b0;
    end else begin
      o_valid <= i_valid;
      o_instr <= i_valid ? i_instr : ~o_instr;
      o_level_later <= i_level_later;
    end
  end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the opcode decoder
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  import iod_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic v = 1'b0;
  logic l = 1'b0;
  logic [31:0] w = 32'h0000_0000;
  logic fv, fl, ov, ores;
  logic [31:0] fw, r, s;
  logic [5:0] oc;
  logic [14:0] ex;
  iod_group_t og;
  iod_op_t oo;
  int error_cnt = 0;
  int checks = 0;
  bit have = 1'b0;
  wire logic [14:0] got = {ov, og, oo, oc, ores};
  always #2 clk = ~clk;
  iod_fetch_model fm (.i_clk(clk), .i_resetn(rstn), .i_valid(v),
    .i_instr(w), .i_level_later(l), .o_valid(fv), .o_instr(fw),
    .o_level_later(fl));
  iod_decoder dut (.i_clk(clk), .i_resetn(rstn), .i_valid(fv),
    .i_instr(fw), .i_level_later(fl), .o_valid(ov), .o_group(og),
    .o_op(oo), .o_code(oc), .o_reserved(ores));
  function automatic logic [14:0] expf(logic vv, logic [31:0] ww, logic ll);
    logic [5:0] op, c;
    logic [4:0] rt;
    logic a;
    iod_group_t g;
    iod_op_t o;
    op = ww[31:26];
    rt = ww[20:16];
    g = IOD_GRP_PRIMARY;
    c = op;
    o = IOD_OP_OTHER;
    a = ll ? IOD_PRI_MAP_LATER[op] : IOD_PRI_MAP_64[op];
    case (op)
      6'h00: begin
        g = IOD_GRP_FUNCTION;
        c = ww[5:0];
        a = ll ? IOD_FN_MAP_LATER[c] : IOD_FN_MAP_64[c];
        o = c == 6'h01 ? IOD_OP_MOVE_ON_FP_FLAG : c == 6'h0a ?
          IOD_OP_MOVE_IF_ZERO : c == 6'h0b ? IOD_OP_MOVE_IF_NONZERO : o;
      end
      6'h01: begin
        g = IOD_GRP_REG_IMM;
        c = {1'b0, rt};
        a = IOD_RT_MAP[rt];
        if (rt[4:3] == 2'h1) begin
          o = rt[2:0] == 3'h6 ? IOD_OP_TRAP_NE_IMM :
            iod_op_t'(IOD_OP_TRAP_GE_IMM + rt[2:0]);
        end
      end
      6'h18, 6'h19, 6'h1a, 6'h1b:
        o = iod_op_t'(IOD_OP_DWORD_ADD_IMM_TRAPPING + op[1:0]);
      6'h37: o = IOD_OP_DWORD_LOAD;
      6'h3f: o = IOD_OP_DWORD_STORE;
      6'h13: o = IOD_OP_FP_EXTENDED_GROUP;
      6'h33: o = IOD_OP_PREFETCH;
      6'h10, 6'h11, 6'h12: o = IOD_OP_COPROC;
      default: ;
    endcase
    if (!a) o = IOD_OP_NONE;
    return {vv, g, o, c, vv & ~a};
  endfunction
  task automatic results();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic step(input logic vv, input logic [31:0] ww, input logic ll);
    @(posedge clk);
    v <= vv;
    w <= ww;
    l <= ll;
    #1;
    if (have) `CHK(got, ex)
    ex = expf(fv, fw, fl);
    have = 1'b1;
  endtask
  initial begin
    void'($urandom(32'h4ff0a3fb));
    repeat (6) @(posedge clk);
    #1 `CHK(got, 15'h0000)
    $display("test reset done");
    @(posedge clk) rstn <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      for (int k = 0; k < 2; k++) begin
        r = $urandom;
        step(1'b1, {i[5:0], r[25:0]}, k[0]);
        step(1'b1, {6'h00, r[25:6], i[5:0]}, k[0]);
        step(1'b1, {6'h01,r[25:21],i[4:0],r[15:0]}, k[0]);
      end
    end
    $display("test corners done");
    // Mid-run reset clears every output
    @(posedge clk) rstn <= 1'b0;
    @(posedge clk) #1 `CHK(got, 15'h0000)
    have = 1'b0;
    @(posedge clk) rstn <= 1'b1;
    $display("test mid reset done");
    repeat (3000) begin
      r = $urandom;
      s = $urandom;
      step(s[0] | s[1], {s[2] ? {5'h00, s[3]} : r[31:26], r[25:0]},
        s[4]);
    end
    $display("test random done");
    results();
  end
  initial begin
    #40000;
    error_cnt++;
    results();
  end
endmodule
